// file: design/pioc_port.sv
// Purpose: one 4-bit port with counter, clock blocks, strobes, pin sharing
// Assumes: pins and external clock arrive asynchronously
// Notes: pin 0 shared with a narrower 1-bit port, pins 0..3 with a link
// Overview of operation
// R01: ports of 1,4,8,16,32 pins offered; only the 4-pin port is built here
// R02: all port pins share one direction
// R03: drive pins or sample with condition wait
// R04: each processor access finishes in one cycle
// R05: open drain drives low or releases
// R06: data passes shifter and transfer register
// R07: 16-bit counter times the pin transfer
// R08: counter readable; transfer may wait on time
// R09: counter captured as timestamp per transfer; here only input words get a timestamp, output transfers get none
// R10: enabled link disables port pins
// R11: enabled port overrules wider overlapping port
// R12: unshared wider port pins stay usable
// R13: port transfers at its full width
// R14: six clock blocks, block zero reference
// R15: clock block may use one-pin port clock
// R16: external clock optionally divided
// R17: ready strobes accepted and generated
// R18: reset selects clock block zero
// R19: counter steps per port clock, wraps
// R20: pin priority: link, narrow, then wide
`timescale 1ns/1ps
module pioc_port
    import pioc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [3:0] pin_in,
    output logic [3:0] pin_out,
    output logic [3:0] pin_oe,
    input wire logic ext_clk_pin,
    input wire logic ready_in_pin,
    output logic output_ready_strobe,
    input wire logic cfg_enable,
    input wire logic cfg_dir_out,
    input wire logic cfg_open_drain,
    input wire logic [2:0] cfg_clk_sel,
    input wire logic cfg_ext_src,
    input wire logic [7:0] cfg_ext_div,
    input wire logic cfg_use_ready,
    input wire logic cfg_cond_en,
    input wire logic [3:0] cfg_cond_val,
    input wire logic cfg_time_en,
    input wire logic [15:0] cfg_time_val,
    input wire logic [1:0] cfg_shift_words,
    input wire logic narrow_enable,
    input wire logic narrow_pin_out,
    input wire logic link_enable,
    input wire logic link_pin_out,
    output logic narrow_pin_in,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [15:0] req_data,
    output logic rsp_valid,
    input wire logic rsp_ready,
    output logic [15:0] rsp_data,
    output logic [15:0] rsp_stamp,
    output logic [15:0] counter_now
);
    logic [3:0] pin_s1_r, pin_s2_r;
    logic ck_s1_r, ck_s2_r, ck_s3_r;
    logic rdy_s1_r, rdy_s2_r;
    logic [2:0] sel_r;
    logic [7:0] ext_cnt_r;
    logic ext_tick_r;
    logic [7:0] ref_cnt_r;
    logic [PIOC_NUM_CLKBLK-1:0] blk_tick;
    logic [15:0] cnt_r;
    pioc_state_t st_r, st_nxt;
    logic [15:0] shift_r;
    logic [1:0] nib_r;
    logic [3:0] drive_r;
    logic [3:0] pin_out_r, pin_oe_r;
    logic strobe_r, narrow_in_r;
    logic [15:0] buf_d [0:1];
    logic [15:0] buf_t [0:1];
    logic wp_r, rp_r;
    logic [1:0] cnt_buf_r;

    // block zero is the reference rate; others pace from the external pin when cfg_ext_src is set, else from block zero
    assign blk_tick[0] = (ref_cnt_r == PIOC_REF_DIV - 8'h01); // R14
    genvar g;
    generate
        for (g = 1; g < PIOC_NUM_CLKBLK; g++) begin : g_blk
            assign blk_tick[g] = cfg_ext_src ? ext_tick_r : blk_tick[0]; // R15
        end
    endgenerate
    wire tick = blk_tick[sel_r];
    wire ext_rise = ck_s2_r & ~ck_s3_r;
    wire time_ok = ~cfg_time_en | (cnt_r == cfg_time_val); // R08
    wire cond_ok = ~cfg_cond_en | (pin_s2_r == cfg_cond_val); // R03
    wire rdy_ok = ~cfg_use_ready | rdy_s2_r; // R17
    wire last_nib = (nib_r == cfg_shift_words);
    wire buf_full = (cnt_buf_r == PIOC_BUF_DEPTH);
    wire buf_empty = (cnt_buf_r == 2'h0);
    wire fire = (st_r == PIOC_XFER) & tick;
    wire in_push = fire & ~cfg_dir_out & last_nib;
    wire push = in_push & ~buf_full;
    wire pop = rsp_valid & rsp_ready;
    // a word is taken only at an edge where ready was already shown
    wire start_out = cfg_enable & cfg_dir_out & req_valid & req_ready & (st_r == PIOC_IDLE); // R04
    wire [15:0] in_word = {pin_s2_r, shift_r[15:4]} >> {cfg_shift_words ^ 2'h3, 2'h0};
    wire rp_nxt = pop ? ~rp_r : rp_r;
    // word pushed into the slot that becomes the head goes straight to the output
    wire head_new = push & (wp_r == rp_nxt);

    // arbitration for pin 0: link, then narrow port, then this port
    function automatic logic [1:0] pioc_owner(input logic lnk, input logic nar);
        pioc_owner = lnk ? 2'h2 : (nar ? 2'h1 : 2'h0); // R20
    endfunction
    wire [1:0] own0 = pioc_owner(link_enable, narrow_enable);

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            PIOC_IDLE: begin
                if (cfg_enable & (start_out | ~cfg_dir_out)) begin
                    st_nxt = PIOC_WAIT;
                end
            end
            PIOC_WAIT: begin
                if (tick & time_ok & cond_ok & rdy_ok) begin
                    st_nxt = PIOC_XFER;
                end
            end
            PIOC_XFER: begin
                if (fire & last_nib & (cfg_dir_out | ~buf_full)) begin
                    st_nxt = PIOC_IDLE;
                end
            end
            default: st_nxt = PIOC_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        pin_s1_r <= pin_in;
        pin_s2_r <= pin_s1_r;
        ck_s1_r <= ext_clk_pin;
        ck_s2_r <= ck_s1_r;
        ck_s3_r <= ck_s2_r;
        rdy_s1_r <= ready_in_pin;
        rdy_s2_r <= rdy_s1_r;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sel_r <= PIOC_CLKSEL_RST; // R18
            ref_cnt_r <= PIOC_DIV_RST;
            ext_cnt_r <= PIOC_DIV_RST;
            ext_tick_r <= 1'b0;
        end else begin
            sel_r <= (cfg_clk_sel < 3'(PIOC_NUM_CLKBLK)) ? cfg_clk_sel : PIOC_CLKSEL_RST;
            ref_cnt_r <= blk_tick[0] ? PIOC_DIV_RST : ref_cnt_r + 8'h01;
            ext_tick_r <= ext_rise & (ext_cnt_r == cfg_ext_div); // R16
            if (ext_rise) begin
                ext_cnt_r <= (ext_cnt_r == cfg_ext_div) ? PIOC_DIV_RST : ext_cnt_r + 8'h01; // R16
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cnt_r <= PIOC_CNT_RST;
        end else if (tick) begin
            cnt_r <= cnt_r + 16'h0001; // R07 R19
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st_r <= PIOC_IDLE;
            shift_r <= PIOC_CNT_RST;
            nib_r <= 2'h0;
            drive_r <= 4'h0;
        end else begin
            st_r <= st_nxt;
            if (start_out) begin
                shift_r <= req_data; // R06
                nib_r <= 2'h0;
            end else if (fire & cfg_dir_out) begin
                drive_r <= shift_r[3:0]; // R03 R13
                shift_r <= {4'h0, shift_r[15:4]};
                nib_r <= last_nib ? 2'h0 : nib_r + 2'h1;
            end else if (fire & (~last_nib | ~buf_full)) begin
                shift_r <= {pin_s2_r, shift_r[15:4]}; // R06 R13
                nib_r <= last_nib ? 2'h0 : nib_r + 2'h1;
            end
        end
    end

    // two-entry transfer buffer towards the processor
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wp_r <= 1'b0;
            rp_r <= 1'b0;
            cnt_buf_r <= 2'h0;
        end else begin
            if (push) begin
                buf_d[wp_r] <= in_word;
                buf_t[wp_r] <= cnt_r; // R09
                wp_r <= ~wp_r;
            end
            if (pop) begin
                rp_r <= ~rp_r;
            end
            cnt_buf_r <= cnt_buf_r + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pin_out_r <= 4'h0;
            pin_oe_r <= 4'h0;
            strobe_r <= 1'b0;
            narrow_in_r <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_data <= PIOC_CNT_RST;
            rsp_stamp <= PIOC_CNT_RST;
            req_ready <= 1'b0;
            counter_now <= PIOC_CNT_RST;
        end else begin
            counter_now <= cnt_r; // R04 R08
            req_ready <= cfg_dir_out & (st_nxt == PIOC_IDLE); // R04
            strobe_r <= fire & cfg_dir_out; // R17
            narrow_in_r <= pin_s2_r[0];
            rsp_valid <= ~buf_empty & ~(pop & (cnt_buf_r == 2'h1)) | push;
            rsp_data <= head_new ? in_word : ((pop & (cnt_buf_r == 2'h2)) ? buf_d[~rp_r] : rsp_data); // R06
            rsp_stamp <= head_new ? cnt_r : ((pop & (cnt_buf_r == 2'h2)) ? buf_t[~rp_r] : rsp_stamp); // R09
            if (own0 == 2'h2) begin
                pin_out_r[0] <= link_pin_out; // R10
                pin_oe_r[0] <= 1'b1;
            end else if (own0 == 2'h1) begin
                pin_out_r[0] <= narrow_pin_out; // R11
                pin_oe_r[0] <= 1'b1;
            end else begin
                pin_out_r[0] <= cfg_open_drain ? 1'b0 : drive_r[0]; // R05
                pin_oe_r[0] <= cfg_enable & cfg_dir_out & (~cfg_open_drain | ~drive_r[0]); // R02 R05
            end
            pin_out_r[3:1] <= cfg_open_drain ? 3'h0 : drive_r[3:1]; // R12
            pin_oe_r[3:1] <= {3{cfg_enable & cfg_dir_out & ~link_enable}} &
                             (cfg_open_drain ? ~drive_r[3:1] : 3'h7); // R02 R05 R10
        end
    end

    assign pin_out = pin_out_r;
    assign pin_oe = pin_oe_r;
    assign output_ready_strobe = strobe_r;
    assign narrow_pin_in = narrow_in_r;
    // only this 4-bit instance is built; R01 widths come from the width constants
endmodule

// file: design/pioc_pkg.sv
// Purpose: constants for the port and clock block unit
// Assumes: single core clock, no register bus
// Notes: widths fixed
package pioc_pkg;
    localparam int PIOC_NUM_CLKBLK = 6;
    localparam int PIOC_CNT_W = 16;
    localparam logic [15:0] PIOC_CNT_RST = 16'h0000;
    localparam logic [2:0] PIOC_CLKSEL_RST = 3'h0;
    localparam logic [7:0] PIOC_DIV_RST = 8'h00;
    localparam int PIOC_WIDTH_1 = 1;
    localparam int PIOC_WIDTH_4 = 4;
    localparam int PIOC_WIDTH_8 = 8;
    localparam int PIOC_WIDTH_16 = 16;
    localparam int PIOC_WIDTH_32 = 32;
    localparam int PIOC_REF_MHZ = 100;
    localparam int PIOC_CLK_MHZ = 250;
    localparam logic [7:0] PIOC_REF_DIV = 8'(PIOC_CLK_MHZ / PIOC_REF_MHZ);
    localparam logic [31:0] PIOC_DATA_RST = 32'h00000000;
    localparam logic [1:0] PIOC_BUF_DEPTH = 2'h2;
    typedef enum logic [1:0] {
        PIOC_IDLE = 2'b00,
        PIOC_WAIT = 2'b01,
        PIOC_XFER = 2'b11
    } pioc_state_t;
endpackage

// file: verif/pioc_chk_assertions.sv
// Purpose: timing checks on the port pins and streams
// Assumes: bound to pioc_port
// Notes: sees top ports only
`timescale 1ns/1ps
module pioc_chk
    import pioc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe,
    input wire logic output_ready_strobe,
    input wire logic cfg_enable,
    input wire logic cfg_dir_out,
    input wire logic cfg_open_drain,
    input wire logic cfg_ext_src,
    input wire logic link_enable,
    input wire logic rsp_valid,
    input wire logic rsp_ready,
    input wire logic [15:0] rsp_data,
    input wire logic [15:0] rsp_stamp,
    input wire logic [15:0] counter_now
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_reset_clears: assert property ($rose(reset_n) |-> counter_now == 16'h0000 && pin_oe == 4'h0 && !rsp_valid)
        else $error("reset state wrong");
    a_od_low_only: assert property (cfg_open_drain && $past(cfg_open_drain) && !link_enable |-> (pin_out & pin_oe) == 4'h0)
        else $error("open drain drove high");
    a_link_owns: assert property (link_enable [*3] |-> pin_oe[3:1] == 3'h0)
        else $error("link pins still driven");
    a_input_quiet: assert property ((!cfg_dir_out && !link_enable) [*3] |-> pin_oe[3:1] == 3'h0)
        else $error("input port drives");
    a_rsp_hold: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data) && $stable(rsp_stamp))
        else $error("word changed while stalled");
    a_count_step: assert property ($past(reset_n) && $changed(counter_now) |-> counter_now == $past(counter_now) + 16'h0001)
        else $error("counter jumped");
    a_ref_pace: assert property ($past(reset_n) && !cfg_ext_src && $changed(counter_now) |=> $stable(counter_now))
        else $error("counter too fast");
    a_ref_alive: assert property (cfg_enable && !cfg_ext_src |-> ##[1:4] $changed(counter_now))
        else $error("counter stopped");
    a_strobe_single: assert property (output_ready_strobe |=> !output_ready_strobe)
        else $error("strobe too long");
endmodule
bind pioc_port pioc_chk u_chk (.clk, .reset_n, .pin_out, .pin_oe, .output_ready_strobe, .cfg_enable, .cfg_dir_out,
    .cfg_open_drain, .cfg_ext_src, .link_enable, .rsp_valid, .rsp_ready, .rsp_data, .rsp_stamp, .counter_now);

// file: verif/pioc_ext_model.sv
// Purpose: pins and clock of the attached hardware
// Assumes: pull-down on every pin
// Notes: clock only runs while asked
`timescale 1ns/1ps
module pioc_ext_model (
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe,
    input wire logic [3:0] drive_val,
    input wire logic drive_en,
    input wire logic ext_run,
    output logic [3:0] pin_in,
    output logic ext_clk_pin
);
    // port wins where it drives, released pins take the device value or fall to the pull-down
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & (drive_en ? drive_val : 4'h0));
    initial begin
        ext_clk_pin = 1'b0;
        forever begin
            #13.7;
            ext_clk_pin = ext_run ? ~ext_clk_pin : 1'b0;
        end
    end
endmodule

// file: verif/pioc_port_test.sv
// Purpose: self-checking bench for the port
// Assumes: inputs change at falling edge
// Notes: bounded waits only
`timescale 1ns/1ps
module pioc_port_test;
    import pioc_pkg::*;
    logic clk, ext_clk_pin, output_ready_strobe, narrow_pin_in, req_ready, rsp_valid;
    logic reset_n = 1'b0, ready_in_pin = 1'b0, cfg_enable = 1'b0, cfg_dir_out = 1'b0, cfg_open_drain = 1'b0;
    logic cfg_ext_src = 1'b0, cfg_use_ready = 1'b0, cfg_cond_en = 1'b0, cfg_time_en = 1'b0, link_pin_out = 1'b0;
    logic narrow_enable = 1'b0, narrow_pin_out = 1'b0, link_enable = 1'b0, req_valid = 1'b0, rsp_ready = 1'b0;
    logic drive_en = 1'b1, ext_run = 1'b0;
    logic [2:0] cfg_clk_sel = 3'h0;
    logic [1:0] cfg_shift_words = 2'h0;
    logic [3:0] cfg_cond_val = 4'h0, drive_val = 4'h9, pin_in, pin_out, pin_oe;
    logic [7:0] cfg_ext_div = 8'h00;
    logic [15:0] cfg_time_val = 16'h0000, req_data = 16'h0000, rsp_data, rsp_stamp, counter_now, t0;
    logic seen;
    int miscompares = 0, n_checks = 0;
    pioc_port u_dut (.clk, .reset_n, .pin_in, .pin_out, .pin_oe, .ext_clk_pin, .ready_in_pin, .output_ready_strobe,
        .cfg_enable, .cfg_dir_out, .cfg_open_drain, .cfg_clk_sel, .cfg_ext_src, .cfg_ext_div, .cfg_use_ready,
        .cfg_cond_en, .cfg_cond_val, .cfg_time_en, .cfg_time_val, .cfg_shift_words, .narrow_enable, .narrow_pin_out,
        .link_enable, .link_pin_out, .narrow_pin_in, .req_valid, .req_ready, .req_data, .rsp_valid, .rsp_ready,
        .rsp_data, .rsp_stamp, .counter_now);
    pioc_ext_model u_ext (.pin_out, .pin_oe, .drive_val, .drive_en, .ext_run, .pin_in, .ext_clk_pin);
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic finish_test;
        if (miscompares == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %0t got %h want %h", $time, got, exp);
        end
    endtask
    // sel 0 strobe, 1 response valid, 2 request ready
    task automatic wait_hi(input int sel);
        for (int k = 0; k < 400; k++) begin
            @(negedge clk);
            if ((sel == 0 ? output_ready_strobe : sel == 1 ? rsp_valid : req_ready) === 1'b1) return;
        end
        miscompares++;
        $display("unexpected %0t timeout", $time);
        finish_test;
    endtask
    task automatic t_output;
        cfg_dir_out = 1'b1;
        cfg_open_drain = 1'b1;
        cfg_use_ready = 1'b1;
        cfg_shift_words = 2'h3;
        cfg_enable = 1'b1;
        req_data = 16'h5a3c;
        req_valid = 1'b1;
        wait_hi(2);
        @(negedge clk);
        req_valid = 1'b0;
        seen = 1'b0;
        repeat (30) begin
            @(negedge clk);
            seen = seen | output_ready_strobe;
        end
        cmp16({15'h0000, seen}, 16'h0000);
        ready_in_pin = 1'b1;
        for (int k = 0; k < 4; k++) begin
            wait_hi(0);
            @(negedge clk);
            cmp16({12'h000, ~pin_oe}, (16'h5a3c >> (4 * k)) & 16'h000f);
        end
        cfg_open_drain = 1'b0;
        cfg_use_ready = 1'b0;
    endtask
    task automatic t_input;
        cfg_shift_words = 2'h1;
        cfg_dir_out = 1'b0;
        wait_hi(1);
        t0 = rsp_stamp;
        repeat (60) @(negedge clk);
        for (int k = 0; k < 3; k++) begin
            cmp16(rsp_data, 16'h0099);
            rsp_ready = 1'b1;
            @(negedge clk);
            rsp_ready = 1'b0;
            wait_hi(1);
        end
        cmp16({15'h0000, rsp_stamp !== t0}, 16'h0001);
        cfg_enable = 1'b0;
        rsp_ready = 1'b1;
        repeat (30) @(negedge clk);
        cmp16({15'h0000, rsp_valid}, 16'h0000);
        rsp_ready = 1'b0;
    endtask
    task automatic t_share;
        narrow_enable = 1'b1;
        for (int k = 0; k < 2; k++) begin
            drive_val = k ? 4'h0 : 4'hf;
            narrow_pin_out = ~drive_val[0];
            repeat (6) @(negedge clk);
            cmp16({15'h0000, narrow_pin_in}, {15'h0000, ~drive_val[0]});
        end
        link_enable = 1'b1;
        cfg_dir_out = 1'b1;
        cfg_enable = 1'b1;
        repeat (6) @(negedge clk);
        cmp16({12'h000, pin_oe & 4'he}, 16'h0000);
        link_enable = 1'b0;
        narrow_enable = 1'b0;
        cfg_enable = 1'b0;
    endtask
    task automatic t_ext;
        cfg_clk_sel = 3'h1;
        cfg_ext_src = 1'b1;
        cfg_ext_div = 8'h01;
        repeat (6) @(negedge clk);
        t0 = counter_now;
        ext_run = 1'b1;
        repeat (8) @(posedge ext_clk_pin);
        ext_run = 1'b0;
        repeat (8) @(negedge clk);
        cmp16(counter_now - t0, 16'h0004);
    endtask
    initial begin
        repeat (4) @(negedge clk);
        cmp16(counter_now, 16'h0000);
        cmp16({12'h000, pin_oe}, 16'h0000);
        reset_n = 1'b1;
        repeat (2) @(negedge clk);
        t_output();
        t_input();
        t_share();
        t_ext();
        finish_test();
    end
endmodule
